// ==== hdl/pin_task_event_unit.v ====
// pin task and event unit: channels driving or watching gpio pins, behind an axi4-lite slave
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`include "pin_task_event_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pin_task_event_unit #(
    parameter CHANNELS = 8,                   // channels of this instance
    parameter PINS     = 32,                  // pins of the port
    parameter PSEL_W   = 5                    // width of the pin select field
) (
    input  wire                  aclk,
    input  wire                  aresetn,
    // axi4-lite slave
    input  wire [11:0]           awaddr,
    input  wire [2:0]            awprot,
    input  wire                  awvalid,
    output reg                   awready,
    input  wire [31:0]           wdata,
    input  wire [3:0]            wstrb,
    input  wire                  wvalid,
    output reg                   wready,
    output reg  [1:0]            bresp,
    output reg                   bvalid,
    input  wire                  bready,
    input  wire [11:0]           araddr,
    input  wire [2:0]            arprot,
    input  wire                  arvalid,
    output reg                   arready,
    output reg  [31:0]           rdata,
    output reg  [1:0]            rresp,
    output reg                   rvalid,
    input  wire                  rready,
    // task triggers and event pulses on the interconnect
    input  wire [CHANNELS-1:0]   out_task_in,
    input  wire [CHANNELS-1:0]   set_task_in,
    input  wire [CHANNELS-1:0]   drive_low_task_in,
    output reg  [CHANNELS-1:0]   edge_event_out,
    output reg                   port_event_open,
    output reg                   port_event_sec,
    // gpio port side
    input  wire [PINS-1:0]       gpio_out_val,
    input  wire [PINS-1:0]       gpio_dir,
    input  wire [PINS-1:0]       pin_in,
    input  wire [PINS-1:0]       pin_sense_hit,
    input  wire                  secure_sense_summary,
    input  wire                  open_sense_summary,
    output reg  [PINS-1:0]       pin_out,
    output reg  [PINS-1:0]       pin_oe_n,
    // power control and interrupts
    input  wire                  system_off_req,
    output reg                   wake_reset,
    output reg                   irq_open,
    output reg                   irq_sec
);

    // channel state
    reg [31:0]           config_reg [0:CHANNELS-1];  // channel setup words
    reg [CHANNELS-1:0]   level_reg;                  // level each task channel drives
    reg [CHANNELS-1:0]   prev_in_reg;                // last sampled level of bound pin
    reg [CHANNELS-1:0]   evt_in_reg;                 // edge event flags
    reg [CHANNELS-1:0]   chan_sec_reg;               // channel security attribute
    reg                  evt_open_reg;               // open port event flag
    reg                  evt_sec_reg;                // secure port event flag
    reg [31:0]           inten_reg;                  // interrupt enables
    reg                  kind_sel_reg;               // 1: latched summary mode
    reg [PINS-1:0]       latch_reg;                  // latched sense flags
    reg [PINS-1:0]       pin_sec_reg;                // pins whose sense counts as secure
    reg                  latch_gap_reg;              // one idle cycle after a latch clear
    reg                  sum_open_prev_reg;          // summary levels one cycle back
    reg                  sum_sec_prev_reg;

    // decode results
    reg [CHANNELS-1:0]   sw_out;
    reg [CHANNELS-1:0]   sw_set;
    reg [CHANNELS-1:0]   sw_low;
    reg [CHANNELS-1:0]   evt_in_clr;
    reg [CHANNELS-1:0]   cfg_we;
    reg                  evt_open_clr;
    reg                  evt_sec_clr;
    reg                  wr_hit;
    reg [31:0]           rd_data;
    reg                  rd_hit;
    reg [PINS-1:0]       pin_out_next;
    reg [PINS-1:0]       pin_oe_n_next;
    integer              i;
    integer              p;

    wire        wr_fire = awvalid & awready;   // write address and data taken together
    wire        rd_fire = arvalid & arready;
    wire        wr_ns   = awprot[1];           // prot bit 1 marks a non-secure access
    wire        rd_ns   = arprot[1];
    wire [31:0] wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [31:0] cur_sec_ien = {14'h0000, 1'b1, 1'b0, {(16 - CHANNELS){1'b0}}, chan_sec_reg};

    // true when addr hits word n of an array starting at base
    function hit;
        input [11:0] addr;
        input [11:0] base;
        input integer n;
        begin
            hit = (addr == base + n[9:0] * 12'h004);
        end
    endfunction

    // write decode: task triggers, event clears, setup strobes
    always @* begin
        sw_out       = {CHANNELS{1'b0}};
        sw_set       = {CHANNELS{1'b0}};
        sw_low       = {CHANNELS{1'b0}};
        evt_in_clr   = {CHANNELS{1'b0}};
        cfg_we       = {CHANNELS{1'b0}};
        evt_open_clr = 1'b0;
        evt_sec_clr  = 1'b0;
        wr_hit       = 1'b0;
        for (i = 0; i < CHANNELS; i = i + 1) begin
            // a non-secure write to a secure channel is silently dropped
            if (hit(awaddr, `OFS_TASK_OUT, i)) begin
                wr_hit    = 1'b1;
                sw_out[i] = wr_fire & wdata[0] & ~(wr_ns & chan_sec_reg[i]);
            end
            if (hit(awaddr, `OFS_TASK_SET, i)) begin
                wr_hit    = 1'b1;
                sw_set[i] = wr_fire & wdata[0] & ~(wr_ns & chan_sec_reg[i]);
            end
            if (hit(awaddr, `OFS_TASK_LOW, i)) begin
                wr_hit    = 1'b1;
                sw_low[i] = wr_fire & wdata[0] & ~(wr_ns & chan_sec_reg[i]);
            end
            if (hit(awaddr, `OFS_EVT_IN, i)) begin
                wr_hit        = 1'b1;
                evt_in_clr[i] = wr_fire & ~wdata[0] & ~(wr_ns & chan_sec_reg[i]);
            end
            if (hit(awaddr, `OFS_CONFIG, i)) begin
                wr_hit    = 1'b1;
                cfg_we[i] = wr_fire & ~(wr_ns & chan_sec_reg[i]);
            end
        end
        if (awaddr == `OFS_EVT_PORT_OPEN) begin
            wr_hit       = 1'b1;
            evt_open_clr = wr_fire & ~wdata[0];
        end
        if (awaddr == `OFS_EVT_PORT_SEC) begin
            wr_hit      = 1'b1;
            evt_sec_clr = wr_fire & ~wdata[0] & ~wr_ns;
        end
        if (awaddr == `OFS_IRQ_ENABLE || awaddr == `OFS_IRQ_DISABLE ||
            awaddr == `OFS_SUMMARY_KIND || awaddr == `OFS_LATCH ||
            awaddr == `OFS_CHAN_SECURE || awaddr == `OFS_PIN_SECURE) begin
            wr_hit = 1'b1;
        end
    end

    // read mux; secure state reads as zero to non-secure code
    always @* begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b0;
        for (i = 0; i < CHANNELS; i = i + 1) begin
            if (hit(araddr, `OFS_TASK_OUT, i) || hit(araddr, `OFS_TASK_SET, i) ||
                hit(araddr, `OFS_TASK_LOW, i)) begin
                rd_hit = 1'b1;                     // tasks read as zero
            end
            if (hit(araddr, `OFS_EVT_IN, i)) begin
                rd_hit  = 1'b1;
                rd_data = {31'h0000_0000, evt_in_reg[i] & ~(rd_ns & chan_sec_reg[i])};
            end
            if (hit(araddr, `OFS_CONFIG, i)) begin
                rd_hit  = 1'b1;
                rd_data = (rd_ns & chan_sec_reg[i]) ? 32'h0000_0000 : config_reg[i];
            end
        end
        case (araddr)
            `OFS_EVT_PORT_OPEN: begin
                rd_hit  = 1'b1;
                rd_data = {31'h0000_0000, evt_open_reg};
            end
            `OFS_EVT_PORT_SEC: begin
                rd_hit  = 1'b1;
                rd_data = {31'h0000_0000, evt_sec_reg & ~rd_ns};
            end
            `OFS_IRQ_ENABLE, `OFS_IRQ_DISABLE: begin
                rd_hit  = 1'b1;
                rd_data = rd_ns ? (inten_reg & ~cur_sec_ien) : inten_reg;
            end
            `OFS_SUMMARY_KIND: begin
                rd_hit  = 1'b1;
                rd_data = {31'h0000_0000, kind_sel_reg};
            end
            `OFS_LATCH: begin
                rd_hit  = 1'b1;
                rd_data = rd_ns ? (latch_reg & ~pin_sec_reg) : latch_reg;
            end
            `OFS_CHAN_SECURE: begin
                rd_hit  = 1'b1;
                rd_data = {{(32 - CHANNELS){1'b0}}, chan_sec_reg};
            end
            `OFS_PIN_SECURE: begin
                rd_hit  = 1'b1;
                rd_data = pin_sec_reg;
            end
            default: begin
                rd_hit  = rd_hit;
                rd_data = rd_data;
            end
        endcase
    end

    // axi4-lite handshakes: both write channels accepted in one cycle, one answer at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= `RESP_OKAY;
            rdata   <= 32'h0000_0000;
        end else begin
            // ready only once both halves are offered, so no half write is ever held
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready  <= awvalid & wvalid & ~awready & ~bvalid;
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            arready <= arvalid & ~arready & ~rvalid;
            if (rd_fire) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // software-owned registers; set from hardware wins over a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            inten_reg     <= `RST_INTEN;
            kind_sel_reg  <= 1'b0;
            latch_reg     <= {PINS{1'b0}};
            chan_sec_reg  <= {CHANNELS{1'b0}};
            pin_sec_reg   <= {PINS{1'b0}};
            latch_gap_reg <= 1'b0;
        end else begin
            latch_gap_reg <= 1'b0;
            if (wr_fire && awaddr == `OFS_IRQ_ENABLE) begin
                inten_reg <= inten_reg | (wdata & wmask & (wr_ns ? ~cur_sec_ien : 32'hffff_ffff));
            end
            if (wr_fire && awaddr == `OFS_IRQ_DISABLE) begin
                inten_reg <= inten_reg & ~(wdata & wmask & (wr_ns ? ~cur_sec_ien : 32'hffff_ffff));
            end
            // summary selector and security attributes are secure-only
            if (wr_fire && !wr_ns && awaddr == `OFS_SUMMARY_KIND && wstrb[0]) begin
                kind_sel_reg <= wdata[0];
            end
            if (wr_fire && !wr_ns && awaddr == `OFS_CHAN_SECURE) begin
                chan_sec_reg <= (chan_sec_reg & ~wmask[CHANNELS-1:0]) |
                                (wdata[CHANNELS-1:0] & wmask[CHANNELS-1:0]);
            end
            if (wr_fire && !wr_ns && awaddr == `OFS_PIN_SECURE) begin
                pin_sec_reg <= (pin_sec_reg & ~wmask) | (wdata & wmask);
            end
            // latched flags: write one to clear, a fresh hit keeps the flag
            if (wr_fire && awaddr == `OFS_LATCH) begin
                latch_reg <= (latch_reg & ~(wdata & wmask & (wr_ns ? ~pin_sec_reg :
                             {PINS{1'b1}}))) | pin_sense_hit;
                latch_gap_reg <= 1'b1;     // drop summary once so leftovers edge again
            end else begin
                latch_reg <= latch_reg | pin_sense_hit;
            end
        end
    end

    // per-channel task and event logic
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            wire [1:0]        mode     = config_reg[g][`CFG_MODE_LSB +: 2];
            wire [PSEL_W-1:0] psel     = config_reg[g][`CFG_PSEL_LSB +: PSEL_W];
            wire [1:0]        pol      = config_reg[g][`CFG_POL_LSB +: 2];
            wire              cur_in   = pin_in[psel];
            wire              t_out    = out_task_in[g] | sw_out[g];
            wire              t_set    = set_task_in[g] | sw_set[g];
            wire              t_low    = drive_low_task_in[g] | sw_low[g];
            wire              new_task = (wdata[`CFG_MODE_LSB +: 2] == `MODE_TASK);
            wire              rise     = cur_in & ~prev_in_reg[g];
            wire              fall     = ~cur_in & prev_in_reg[g];
            reg               edge_hit;

            // which edges count for this channel
            always @* begin
                case (pol)
                    `POL_HIGH:   edge_hit = rise;
                    `POL_LOW:    edge_hit = fall;
                    `POL_TOGGLE: edge_hit = rise | fall;
                    default:     edge_hit = 1'b0;
                endcase
            end

            always @(posedge aclk) begin
                if (!aresetn) begin
                    config_reg[g]     <= `RST_CONFIG;
                    level_reg[g]      <= 1'b0;
                    prev_in_reg[g]    <= 1'b0;
                    evt_in_reg[g]     <= 1'b0;
                    edge_event_out[g] <= 1'b0;
                end else begin
                    prev_in_reg[g] <= cur_in;
                    if (cfg_we[g]) begin
                        config_reg[g] <= (config_reg[g] & ~wmask) | (wdata & wmask);
                    end
                    // level: mode entry first, then out, low, set by priority
                    if (cfg_we[g] && wstrb[0] && new_task && mode != `MODE_TASK) begin
                        level_reg[g] <= wstrb[2] ? wdata[`CFG_INIT_BIT]
                                                 : config_reg[g][`CFG_INIT_BIT];
                    end else if (mode == `MODE_TASK) begin
                        if (t_out) begin
                            case (pol)
                                `POL_HIGH:   level_reg[g] <= 1'b1;
                                `POL_LOW:    level_reg[g] <= 1'b0;
                                `POL_TOGGLE: level_reg[g] <= ~level_reg[g];
                                default:     level_reg[g] <= level_reg[g];
                            endcase
                        end else if (t_low) begin
                            level_reg[g] <= 1'b0;
                        end else if (t_set) begin
                            level_reg[g] <= 1'b1;
                        end
                    end
                    // edge event flag: a new edge beats a clear in the same cycle
                    edge_event_out[g] <= (mode == `MODE_EVENT) & edge_hit;
                    evt_in_reg[g] <= ((mode == `MODE_EVENT) & edge_hit) |
                                     (evt_in_reg[g] & ~evt_in_clr[g]);
                end
            end
        end
    endgenerate

    // pin ownership: a channel in task or event mode overrides the port for its pin
    always @* begin
        pin_out_next  = gpio_out_val;
        pin_oe_n_next = ~gpio_dir;
        for (p = 0; p < PINS; p = p + 1) begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (config_reg[i][`CFG_PSEL_LSB +: PSEL_W] == p[PSEL_W-1:0]) begin
                    if (config_reg[i][`CFG_MODE_LSB +: 2] == `MODE_TASK) begin
                        pin_out_next[p]  = level_reg[i];
                        pin_oe_n_next[p] = 1'b0;
                    end else if (config_reg[i][`CFG_MODE_LSB +: 2] == `MODE_EVENT) begin
                        pin_oe_n_next[p] = 1'b1;
                    end
                end
            end
        end
    end

    // summaries: raw port signals, or the or of latched flags split by pin security
    wire sum_open_now = kind_sel_reg ? (|(latch_reg & ~pin_sec_reg) & ~latch_gap_reg)
                                     : open_sense_summary;
    wire sum_sec_now  = kind_sel_reg ? (|(latch_reg & pin_sec_reg) & ~latch_gap_reg)
                                     : secure_sense_summary;
    wire rise_open    = sum_open_now & ~sum_open_prev_reg;
    wire rise_sec     = sum_sec_now & ~sum_sec_prev_reg;

    // port events, pin drive, wakeup and interrupt lines, all registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            sum_open_prev_reg <= 1'b0;
            sum_sec_prev_reg  <= 1'b0;
            evt_open_reg      <= 1'b0;
            evt_sec_reg       <= 1'b0;
            port_event_open   <= 1'b0;
            port_event_sec    <= 1'b0;
            pin_out           <= {PINS{1'b0}};
            pin_oe_n          <= {PINS{1'b1}};
            wake_reset        <= 1'b0;
            irq_open          <= 1'b0;
            irq_sec           <= 1'b0;
        end else begin
            sum_open_prev_reg <= sum_open_now;
            sum_sec_prev_reg  <= sum_sec_now;
            port_event_open   <= rise_open;
            port_event_sec    <= rise_sec;
            evt_open_reg      <= rise_open | (evt_open_reg & ~evt_open_clr);
            evt_sec_reg       <= rise_sec | (evt_sec_reg & ~evt_sec_clr);
            pin_out           <= pin_out_next;
            pin_oe_n          <= pin_oe_n_next;
            // held while off is requested with a summary high
            wake_reset        <= system_off_req & (sum_open_now | sum_sec_now);
            // each line has a fixed domain: irq_open non-secure channels and open port event, irq_sec secure channels and secure port event
            irq_open <= |(evt_in_reg & inten_reg[CHANNELS-1:0] & ~chan_sec_reg) |
                        (evt_open_reg & inten_reg[`IEN_PORT_OPEN]);
            irq_sec  <= |(evt_in_reg & inten_reg[CHANNELS-1:0] & chan_sec_reg) |
                        (evt_sec_reg & inten_reg[`IEN_PORT_SEC]);
        end
    end

endmodule // pin_task_event_unit

`default_nettype wire

// ==== hdl/pin_task_event_regs.vh ====
// register offsets, field positions, codes and reset values of the pin task and event unit
`ifndef PIN_TASK_EVENT_REGS_VH
`define PIN_TASK_EVENT_REGS_VH

// byte offsets, channel arrays step by one word
`define OFS_TASK_OUT        12'h000
`define OFS_TASK_SET        12'h030
`define OFS_TASK_LOW        12'h060
`define OFS_EVT_IN          12'h100
`define OFS_EVT_PORT_OPEN   12'h140
`define OFS_EVT_PORT_SEC    12'h144
`define OFS_IRQ_ENABLE      12'h304
`define OFS_IRQ_DISABLE     12'h308
`define OFS_CONFIG          12'h510
`define OFS_SUMMARY_KIND    12'h600
`define OFS_LATCH           12'h604
`define OFS_CHAN_SECURE     12'h608
`define OFS_PIN_SECURE      12'h60c

// channel setup fields
`define CFG_MODE_LSB        0
`define CFG_PSEL_LSB        8
`define CFG_POL_LSB         16
`define CFG_INIT_BIT        20

// mode codes
`define MODE_DISABLED       2'h0
`define MODE_EVENT          2'h1
`define MODE_TASK           2'h3

// task action / edge condition codes
`define POL_NONE            2'h0
`define POL_HIGH            2'h1
`define POL_LOW             2'h2
`define POL_TOGGLE          2'h3

// interrupt enable bit positions for the two port events
`define IEN_PORT_OPEN       16
`define IEN_PORT_SEC        17

// reset values
`define RST_CONFIG          32'h0000_0000
`define RST_INTEN           32'h0000_0000

// bus answers
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== test/pin_task_event_props.sv ====
// checker: bus answers, port events and wakeup of the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
module pin_task_event_props (
    input wire logic aclk, aresetn, awready, wready, bvalid, bready, arready,
    input wire logic rvalid, rready, open_sense_summary, secure_sense_summary,
    input wire logic port_event_open, port_event_sec, system_off_req, wake_reset,
    input wire logic [1:0] bresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address and data must be taken in the same cycle
    a_take_pair: assert property (awready == wready) else $error("ready split");
    a_write_answer: assert property (awready |=> bvalid) else $error("no bresp");
    a_bvalid_drop: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
    a_read_answer: assert property (arready |=> rvalid && !arready) else $error("no rdata");
    a_rvalid_drop: assert property (rvalid && rready |=> !rvalid) else $error("rvalid stuck");
    a_open_port: assert property ($rose(open_sense_summary) |=> port_event_open)
        else $error("open port event missing");
    a_sec_port: assert property ($rose(secure_sense_summary) |=> port_event_sec)
        else $error("secure port event missing");
    // a level summary must not give a stream of events
    a_port_pulse: assert property (port_event_open |=> !port_event_open)
        else $error("port event longer than a pulse");
    a_off_wakeup: assert property (system_off_req && open_sense_summary |=> wake_reset)
        else $error("no wakeup reset");
    c_slverr: cover property (bvalid && bresp == 2'h2);
    c_port: cover property (port_event_open);
    c_wake: cover property (wake_reset);
endmodule // pin_task_event_props
bind pin_task_event_unit pin_task_event_props chk (.*);
`default_nettype wire

// ==== test/gpio_pins_model.sv ====
// far-side pins: a driven pin reads back its own level, a released pin the outside level
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    input  wire logic [31:0] ext_lvl,
    output logic      [31:0] pin_in
);
    // per pin mux on the active-low enable
    assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule // gpio_pins_model
`default_nettype wire

// ==== test/tb_top.sv ====
// bench for the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
`include "pin_task_event_regs.vh"
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, seen = 0, e;
    logic bready = 1, rready = 1, system_off_req = 0;
    logic secure_sense_summary = 0, open_sense_summary = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [2:0] awprot = '0, arprot = '0;
    logic [3:0] wstrb = 4'hf;
    logic [4:0] p, q;
    logic [7:0] out_task_in = '0, set_task_in = '0, drive_low_task_in = '0;
    logic [31:0] wdata = '0, gpio_out_val, gpio_dir, pin_sense_hit, ext_lvl = '0;
    logic [31:0] seed = 32'h21;
    logic [33:0] expq[$];
    wire awready, wready, bvalid, arready, rvalid, wake_reset, irq_open, irq_sec;
    wire port_event_open, port_event_sec;
    wire [1:0] bresp, rresp;
    wire [7:0] edge_event_out;
    wire [31:0] rdata, pin_out, pin_oe_n, pin_in;
    int fail_count = 0, check_count = 0, n;
    localparam logic [33:0] OK = {`RESP_OKAY, 32'h0};
    pin_task_event_unit dut (.*);
    gpio_pins_model pins (.*);
    always #20 aclk = ~aclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] cfg(logic [1:0] m, logic [4:0] s, logic [1:0] a, logic i);
        return {11'h0, i, 2'h0, a, 3'h0, s, 6'h0, m};
    endfunction
    task automatic ck(string nm, logic [33:0] x, logic [33:0] s);
        check_count++;
        if (x !== s) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // answers meet the oldest queued note; channel 1 edge events stick in seen
    always @(posedge aclk) begin
        if (bvalid && bready) ck("bresp", expq.pop_front(), {bresp, 32'h0});
        if (rvalid && rready) ck("rdata", expq.pop_front(), {rresp, rdata});
        if (edge_event_out[1]) seen <= 1'b1;
    end
    // one access, request held until its ready is sampled, then wait for the answer
    task automatic bus(logic w, logic [11:0] a, logic [33:0] x, logic [31:0] d = 0,
                       logic [2:0] pr = 0);
        n = 0;
        expq.push_back(x);
        if (w) {awaddr, awprot, wdata, awvalid, wvalid} <= {a, pr, d, 2'h3};
        else {araddr, arprot, arvalid} <= {a, pr, 1'b1};
        do @(posedge aclk); while (!(awready || arready) && ++n < 60);
        {awvalid, wvalid, arvalid} <= 3'h0;
        do @(posedge aclk); while (!(bvalid || rvalid) && ++n < 60);
        if (n >= 60) begin
            fail_count++;
            close_out();
        end
    endtask
    // channel 0 tasks {out, low, set}; the pin settles two edges after the trigger
    task automatic fire(logic [2:0] m);
        {out_task_in[0], drive_low_task_in[0], set_task_in[0]} <= m;
        @(posedge aclk);
        {out_task_in[0], drive_low_task_in[0], set_task_in[0]} <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask
    initial begin
        {gpio_dir, gpio_out_val, pin_sense_hit} <= {rnd(), rnd(), rnd()};
        p = 5'(rnd());
        q = p ^ 5'h10;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, `OFS_IRQ_DISABLE, {`RESP_OKAY, `RST_INTEN});
        bus(1, 12'hffc, {`RESP_SLVERR, 32'h0}, 32'h1);
        bus(0, 12'hffc, {`RESP_SLVERR, 32'h0});
        bus(1, `OFS_SUMMARY_KIND, OK);
        bus(1, `OFS_CHAN_SECURE, OK);
        gpio_out_val <= 32'h0;
        bus(1, `OFS_CONFIG, OK, cfg(`MODE_TASK, p, `POL_TOGGLE, 1'b1));
        repeat (3) @(posedge aclk);
        ck("init", 34'h1, pin_out[p]);
        ck("drive", 34'h0, pin_oe_n[p]);
        for (int k = 0; k < 8; k++) begin
            bus(1, `OFS_CONFIG, OK, cfg(`MODE_TASK, p, 2'(k / 2), 1'b0));
            fire(k[0] ? 3'h1 : 3'h2);
            fire(3'h7);
            e = (k < 2) ? k[0] : (k > 5) ? !k[0] : (k < 4);
            ck("prio", e, pin_out[p]);
        end
        bus(1, `OFS_CONFIG, OK, cfg(`MODE_DISABLED, p, 2'h0, 1'b0));
        repeat (3) @(posedge aclk);
        ck("free", {gpio_dir[p], gpio_out_val[p]}, {~pin_oe_n[p], pin_out[p]});
        $display("test tasks done");
        bus(1, `OFS_CONFIG + 12'h4, OK, cfg(`MODE_EVENT, q, `POL_TOGGLE, 1'b0));
        repeat (3) @(posedge aclk);
        ck("input", 34'h1, pin_oe_n[q]);
        seen <= 1'b0;
        bus(1, `OFS_EVT_IN + 12'h4, OK);
        ext_lvl <= ext_lvl ^ (32'h1 << q);
        repeat (4) @(posedge aclk);
        ck("edge", 34'h1, seen);
        bus(0, `OFS_EVT_IN + 12'h4, OK | 34'h1);
        bus(1, `OFS_IRQ_ENABLE, OK, 32'h2);
        repeat (2) @(posedge aclk);
        ck("irq", 34'h1, irq_open);
        bus(1, `OFS_EVT_IN + 12'h4, OK);
        repeat (2) @(posedge aclk);
        ck("irq_off", 34'h0, irq_open);
        $display("test events done");
        bus(1, `OFS_IRQ_DISABLE, OK, 32'h0003_0000);
        {open_sense_summary, secure_sense_summary} <= 2'h3;
        repeat (3) @(posedge aclk);
        bus(0, `OFS_EVT_PORT_OPEN, OK | 34'h1);
        bus(0, `OFS_EVT_PORT_SEC, OK, 32'h0, 3'h2);
        bus(0, `OFS_EVT_PORT_SEC, OK | 34'h1);
        bus(1, `OFS_EVT_PORT_OPEN, OK);
        bus(1, `OFS_EVT_PORT_SEC, OK);
        bus(1, `OFS_IRQ_ENABLE, OK, 32'h0003_0000);
        repeat (2) @(posedge aclk);
        ck("quiet", 34'h0, {irq_open, irq_sec});
        system_off_req <= 1'b1;
        repeat (2) @(posedge aclk);
        ck("wake", 34'h1, wake_reset);
        {open_sense_summary, secure_sense_summary} <= 2'h0;
        repeat (2) @(posedge aclk);
        ck("wake_off", 34'h0, wake_reset);
        secure_sense_summary <= 1'b1;
        repeat (3) @(posedge aclk);
        ck("irq_sec", 34'h1, irq_sec);
        $display("test port done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
